/* vg_defines.svh */
// register map, field positions, reset values and line mapping constants
`ifndef VG_DEFINES_SVH
`define VG_DEFINES_SVH

`define VG_ADDR_START 8'h15
`define VG_ADDR_STOP 8'h16
`define VG_ADDR_MISC 8'h17

`define VG_MISC_START_MSB 0
`define VG_MISC_STOP_MSB 1
`define VG_MISC_SHIFT 2
`define VG_MISC_DETECT_SEARCH_LATENCY_LO 3
`define VG_MISC_DETECT_SEARCH_LATENCY_HI 5
`define VG_MISC_HALF_DIS 6
`define VG_MISC_LINE_DIS 7

`define VG_RST_START 8'h00
`define VG_RST_STOP 8'h00
`define VG_RST_MISC 8'h18

`define VG_DETECT_SEARCH_LATENCY_RESERVED 3'h0
`define VG_DETECT_SEARCH_LATENCY_RECOMMENDED 3'h3
`define VG_FMT_MOD656 3'h1

// 50 Hz frame lines and programmed-value offsets
`define VG_P_F1_WRAP 10'h001
`define VG_P_F1_LAST 10'h139
`define VG_P_F2_WRAP 10'h13a
`define VG_P_F1_OFS 10'h002
`define VG_P_F2_OFS 10'h13b
`define VG_P_WRAP_VAL 9'h138
// 60 Hz frame lines and programmed-value offsets
`define VG_N_F2_TAIL 10'h003
`define VG_N_F1_WRAP 10'h004
`define VG_N_F1_LAST 10'h10a
`define VG_N_F2_WRAP 10'h10b
`define VG_N_F1_OFS 10'h005
`define VG_N_F2_OFS 10'h10c
`define VG_N_TAIL_OFS 10'h101
`define VG_N_WRAP_VAL 9'h106

`define VG_FIRST_LINE 10'h001

`endif

/* vg_pkg.sv */
// types shared by the vertical gate block
package vg_pkg;

  // register access as delivered by the serial control bus
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } vg_reg_req_t;

  // line timing from the decoder's line counter
  typedef struct packed {
    logic lineStrobe;
    logic frameStart;
    logic is60Hz;
  } vg_timing_t;

  // position of a frame line in programmed-value terms
  typedef struct packed {
    logic field2;
    logic [8:0] val;
  } vg_pos_t;

endpackage

/* vg_vertical_gate.sv */
// vertical gate, field identifier and miscellaneous control registers
`timescale 1ns/1ps
`default_nettype none
`include "vg_defines.svh"

module vg_vertical_gate (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire vg_pkg::vg_reg_req_t regReq,
  output logic [7:0] regRdData,
  // line timing and output format
  input wire vg_pkg::vg_timing_t timing,
  input wire logic [2:0] expansionOutputFormat,
  // gate and field outputs
  output logic verticalGate,
  output logic fieldIdent,
  output logic fieldBlank,
  // clock output drive control, high means high impedance
  output logic lineClockOutDisable,
  output logic halfLineClockOutDisable,
  // standard search latency in fields
  output logic [2:0] detectSearchLatency
);
  import vg_pkg::*;

  logic [7:0] startLow_r;
  logic [7:0] stopLow_r;
  logic [7:0] misc_r;
  logic [9:0] frameLine_r;
  logic [9:0] frameLine_nxt;
  logic gate_r;
  logic fid_r;
  logic [7:0] rdData_r;
  logic [8:0] gateStartLine;
  logic [8:0] gateStopLine;
  logic gatePositionShift;
  logic [2:0] latyCode;
  vg_pos_t pos;
  logic [8:0] cmpVal;
  logic [8:0] wrapVal;
  logic hitStart;
  logic hitStop;
  logic hitStartRaw;

  // map a frame line to its field and programmed value
  function automatic vg_pos_t vgLinePos(input logic [9:0] l,
                                        input logic ntsc);
    vg_pos_t p;
    p = '0;
    if (!ntsc) begin
      if (l == `VG_P_F1_WRAP) begin
        p = {1'b0, `VG_P_WRAP_VAL};
      end else if (l <= `VG_P_F1_LAST) begin
        p = {1'b0, 9'(l - `VG_P_F1_OFS)};
      end else if (l == `VG_P_F2_WRAP) begin
        p = {1'b1, `VG_P_WRAP_VAL};
      end else begin
        p = {1'b1, 9'(l - `VG_P_F2_OFS)};
      end
    end else begin
      if (l <= `VG_N_F2_TAIL) begin
        p = {1'b1, 9'(l + `VG_N_TAIL_OFS)};
      end else if (l == `VG_N_F1_WRAP) begin
        p = {1'b0, `VG_N_WRAP_VAL};
      end else if (l <= `VG_N_F1_LAST) begin
        p = {1'b0, 9'(l - `VG_N_F1_OFS)};
      end else if (l == `VG_N_F2_WRAP) begin
        p = {1'b1, `VG_N_WRAP_VAL};
      end else begin
        p = {1'b1, 9'(l - `VG_N_F2_OFS)};
      end
    end
    return p;
  endfunction

  // register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startLow_r <= `VG_RST_START;
      stopLow_r <= `VG_RST_STOP;
      misc_r <= `VG_RST_MISC;
    end else if (regReq.wrEn) begin
      case (regReq.addr)
        `VG_ADDR_START: startLow_r <= regReq.wrData;
        `VG_ADDR_STOP: stopLow_r <= regReq.wrData;
        `VG_ADDR_MISC: misc_r <= regReq.wrData;
        default: ;
      endcase
    end
  end

  // register reads answer one cycle after the request; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (regReq.rdEn) begin
      case (regReq.addr)
        `VG_ADDR_START: rdData_r <= startLow_r;
        `VG_ADDR_STOP: rdData_r <= stopLow_r;
        `VG_ADDR_MISC: rdData_r <= misc_r;
        default: rdData_r <= 8'h00;
      endcase
    end
  end
  assign regRdData = rdData_r;

  assign gateStartLine = {misc_r[`VG_MISC_START_MSB], startLow_r};
  assign gateStopLine = {misc_r[`VG_MISC_STOP_MSB], stopLow_r};
  assign gatePositionShift = misc_r[`VG_MISC_SHIFT];
  assign latyCode = misc_r[`VG_MISC_DETECT_SEARCH_LATENCY_HI:`VG_MISC_DETECT_SEARCH_LATENCY_LO];

  // frame line counter, line 1 marked by frameStart
  always_comb begin
    frameLine_nxt = frameLine_r;
    if (timing.lineStrobe) begin
      frameLine_nxt = timing.frameStart ? `VG_FIRST_LINE
                                        : 10'(frameLine_r + 10'h001);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frameLine_r <= `VG_FIRST_LINE;
    end else begin
      frameLine_r <= frameLine_nxt;
    end
  end

  assign pos = vgLinePos(frameLine_nxt, timing.is60Hz);
  // comparing one value ahead moves every field-2 edge but one at the wrap value a line earlier;
  // the wrap line of field 2 stands just before value zero, not after it
  assign wrapVal = timing.is60Hz ? `VG_N_WRAP_VAL : `VG_P_WRAP_VAL;
  assign cmpVal = (gatePositionShift && pos.field2) ?
                  ((pos.val == wrapVal) ? 9'h000 : 9'(pos.val + 9'h001))
                  : pos.val;
  assign hitStart = timing.lineStrobe && (cmpVal == gateStartLine);
  assign hitStop = timing.lineStrobe && (cmpVal == gateStopLine);
  assign hitStartRaw = timing.lineStrobe && (pos.val == gateStartLine);

  // stop wins when start equals stop, so such a gate never opens
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_r <= 1'b0;
    end else if (hitStop) begin
      gate_r <= 1'b0;
    end else if (hitStart) begin
      gate_r <= 1'b1;
    end
  end

  // field identifier keeps the unshifted start position
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fid_r <= 1'b0;
    end else if (hitStartRaw) begin
      fid_r <= ~fid_r;
    end
  end

  assign verticalGate = gate_r;
  assign fieldIdent = fid_r;
  assign fieldBlank = (expansionOutputFormat == `VG_FMT_MOD656)
                      && !gate_r;
  assign lineClockOutDisable = misc_r[`VG_MISC_LINE_DIS];
  assign halfLineClockOutDisable = misc_r[`VG_MISC_HALF_DIS];
  // the reserved code falls back to the advised three fields
  assign detectSearchLatency = (latyCode == `VG_DETECT_SEARCH_LATENCY_RESERVED) ?
                               `VG_DETECT_SEARCH_LATENCY_RECOMMENDED : latyCode;

  a_gate_rise: assert property (
    @(posedge ref_clk) disable iff (rst)
    hitStart && !hitStop |=> verticalGate)
    else $error("gate did not rise at start line");

  a_fid_toggle: assert property (
    @(posedge ref_clk) disable iff (rst)
    hitStartRaw |=> fieldIdent != $past(fieldIdent))
    else $error("field ident did not toggle at start line");

  a_gate_fall: assert property (
    @(posedge ref_clk) disable iff (rst)
    hitStop |=> !verticalGate)
    else $error("gate did not fall at stop line");

  a_pal_map: assert property (
    @(posedge ref_clk) disable iff (rst)
    timing.lineStrobe && !timing.is60Hz && frameLine_nxt == 10'h13a
    |-> pos.field2 && pos.val == 9'h138)
    else $error("50 Hz line 314 not mapped to value 312");

  a_ntsc_map: assert property (
    @(posedge ref_clk) disable iff (rst)
    timing.lineStrobe && timing.is60Hz && frameLine_nxt == 10'h003
    |-> pos.field2 && pos.val == 9'h104)
    else $error("60 Hz line 3 not mapped to value 260");

  a_shift_early: assert property (
    @(posedge ref_clk) disable iff (rst)
    timing.lineStrobe && gatePositionShift && pos.field2
    && pos.val != wrapVal
    && 9'(pos.val + 9'h001) == gateStartLine && !hitStop
    |=> verticalGate)
    else $error("shifted gate not one line early in field 2");

  a_clk_disable: assert property (
    @(posedge ref_clk) disable iff (rst)
    regReq.wrEn && regReq.addr == `VG_ADDR_MISC
    |=> lineClockOutDisable == $past(regReq.wrData[7])
        && halfLineClockOutDisable == $past(regReq.wrData[6]))
    else $error("clock output disable not following misc write");

  a_latency_val: assert property (
    @(posedge ref_clk) disable iff (rst)
    regReq.wrEn && regReq.addr == `VG_ADDR_MISC
    && regReq.wrData[5:3] == 3'h5 |=> detectSearchLatency == 3'h5)
    else $error("search latency not taken from misc write");

  a_blank_fmt: assert property (
    @(posedge ref_clk) disable iff (rst)
    expansionOutputFormat == `VG_FMT_MOD656 |-> fieldBlank == !verticalGate)
    else $error("field blanking does not follow gate");

  a_gate_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !timing.lineStrobe |=> $stable(verticalGate))
    else $error("gate changed between lines");

endmodule
`default_nettype wire

/* vg_capture_model.sv */
// downstream capture stand-in that counts vertical gate openings
`timescale 1ns/1ps
`default_nettype none
module vg_capture_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // gate from the block
  input wire logic verticalGate,
  // openings seen since reset
  output logic [7:0] openCount
);
  logic lastGate_r;

  // an opening is a low-to-high step seen at the clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastGate_r <= 1'b0;
      openCount <= 8'h00;
    end else begin
      lastGate_r <= verticalGate;
      if (verticalGate && !lastGate_r) begin
        openCount <= openCount + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* vg_vertical_gate_tb.sv */
// self-checking bench for the vertical gate block
`timescale 1ns/1ps
`default_nettype none
module vg_vertical_gate_tb;
  import vg_pkg::*;
  logic ref_clk, rst, gate, field_ident, blank, llDis, hlDis, eg, ef;
  vg_reg_req_t regReq;
  vg_timing_t timing;
  logic [2:0] fmt, detect_search_latency;
  logic [7:0] rdData, opens, expOpens;
  int badCount, checksDone;

  vg_vertical_gate i_dut (.ref_clk(ref_clk), .rst(rst), .regReq(regReq),
    .regRdData(rdData), .timing(timing), .expansionOutputFormat(fmt),
    .verticalGate(gate), .fieldIdent(field_ident), .fieldBlank(blank),
    .lineClockOutDisable(llDis), .halfLineClockOutDisable(hlDis),
    .detectSearchLatency(detect_search_latency));
  vg_capture_model i_cap (.ref_clk(ref_clk), .rst(rst),
    .verticalGate(gate), .openCount(opens));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    $display("checks=%0d mismatches=%0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a leading edge keeps each request apart from the previous release
  task automatic tick();
    @(posedge ref_clk);
    #10;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    tick();
    regReq.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick();
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    tick();
    regReq.rdEn = 1'b0;
    tick();
    chk(rdData, exp);
  endtask

  // one frame line; expectations follow the line-to-value mapping
  task automatic line(input int l, input bit n, input bit sh,
                      input logic [8:0] sa, input logic [8:0] so);
    logic f2;
    logic [8:0] v, c;
    f2 = n ? (l <= 3 || l >= 267) : l >= 314;
    v = n ? 9'(l <= 3 ? l + 257 : (l == 4 || l == 267) ? 262 :
              f2 ? l - 268 : l - 5)
          : 9'((l == 1 || l == 314) ? 312 : f2 ? l - 315 : l - 2);
    c = (f2 && sh) ? ((v == (n ? 9'h106 : 9'h138)) ? 9'h000
                                                   : 9'(v + 9'h001)) : v;
    tick();
    timing = '{lineStrobe: 1'b1, frameStart: l == 1, is60Hz: n};
    tick();
    timing.lineStrobe = 1'b0;
    if (c == so) begin
      eg = 1'b0;
    end else if (c == sa && !eg) begin
      eg = 1'b1;
      expOpens++;
    end
    if (v == sa) begin
      ef = ~ef;
    end
    chk({7'h0, gate}, {7'h0, eg});
    chk({7'h0, field_ident}, {7'h0, ef});
    chk({7'h0, blank}, {7'h0, fmt == 3'h1 && !eg});
  endtask

  task automatic frame(input bit n, input bit sh, input logic [8:0] sa,
                       input logic [8:0] so);
    wr(8'h15, sa[7:0]);
    wr(8'h16, so[7:0]);
    wr(8'h17, {5'b00011, sh, so[8], sa[8]});
    for (int l = 1; l <= (n ? 525 : 625); l++) begin
      line(l, n, sh, sa, so);
    end
    chk(opens, expOpens);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // whole run needs about 6000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    endOfTest();
  end

  initial begin
    rst = 1'b1;
    regReq = '0;
    timing = '0;
    fmt = 3'h1;
    eg = 1'b0;
    ef = 1'b0;
    expOpens = 8'h00;
    badCount = 0;
    checksDone = 0;
    repeat (20) @(posedge ref_clk);
    #10;
    rst = 1'b0;
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h18);
    rd(8'h3c, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h17, {i[0], i[1], 3'(i), 3'h0});
      rd(8'h17, {i[0], i[1], 3'(i), 3'h0});
      chk({llDis, hlDis, 3'h0, detect_search_latency},
          {i[0], i[1], 3'h0, i == 0 ? 3'h3 : 3'(i)});
    end
    frame(1'b0, 1'b0, 9'h000, 9'h136);
    fmt = 3'h0;
    frame(1'b0, 1'b1, 9'h005, 9'h12c);
    fmt = 3'h1;
    frame(1'b1, 1'b0, 9'h106, 9'h104);
    frame(1'b1, 1'b1, 9'h00a, 9'h00a);
    frame(1'b0, 1'b1, 9'h000, 9'h064);
    endOfTest();
  end
endmodule
`default_nettype wire
